// File: common/lcd_pkg.sv
package lcd_pkg;
    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W   = 4;
    localparam int unsigned DATA_W   = 8;
    localparam logic [3:0]  CTRL_OFS = 4'h0;
    localparam logic [3:0]  STAT_OFS = 4'h1;
    localparam logic [3:0]  EVT_OFS  = 4'h2;
    localparam logic [3:0]  MASK_OFS = 4'h3;
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [2:0]  MASK_RST = 3'h0;
    localparam logic [2:0]  EVT_RST  = 3'h0;
    // Control bits
    localparam int unsigned CTL_PAT  = 0;
    localparam int unsigned CTL_INS  = 1;
    localparam int unsigned CTL_RLB  = 2;
    localparam int unsigned CTL_LLB  = 3;
    localparam int unsigned CTL_AOS  = 4;
    localparam int unsigned CTL_DUAL = 5;
    localparam int unsigned CTL_E3   = 6;
    // Status and event bits
    localparam int unsigned ST_LOST  = 0;
    localparam int unsigned ST_MODE  = 4;
    localparam int unsigned EV_LOST  = 0;
    localparam int unsigned EV_GAIN  = 1;
    localparam int unsigned EV_ERR   = 2;
    localparam int unsigned EV_W     = 3;
    // ------------------------------------------------------------
    // Link inputs, pattern engine
    // ------------------------------------------------------------
    localparam int unsigned LK_TXC   = 0;
    localparam int unsigned LK_TXP   = 1;
    localparam int unsigned LK_TXN   = 2;
    localparam int unsigned LK_RXC   = 3;
    localparam int unsigned LK_RXT   = 4;
    localparam int unsigned LK_RXR   = 5;
    localparam int unsigned LK_W     = 6;
    localparam int unsigned LFSR_W   = 23;
    localparam logic [22:0] LFSR_RST = 23'h7fffff;
    localparam int unsigned LONG_TOP = 22;
    localparam int unsigned LONG_TAP = 17;
    localparam int unsigned SHRT_TOP = 14;
    localparam int unsigned SHRT_TAP = 13;
    localparam logic [5:0]  GOOD_RUN = 6'h20;
    localparam logic [2:0]  LOSS_ERR = 3'h4;

    typedef enum logic [3:0] {
        LB_NORMAL  = 4'h1,
        LB_ANALOG  = 4'h2,
        LB_REMOTE  = 4'h4,
        LB_DIGITAL = 4'h8
    } lcd_loop_e;

    typedef enum logic [1:0] {
        CHK_HUNT = 2'h1,
        CHK_LOCK = 2'h2
    } lcd_chk_e;

    function automatic lcd_loop_e loop_decode(input logic rlb, input logic llb);
        unique case ({rlb, llb})
            2'b00: loop_decode = LB_NORMAL;
            2'b01: loop_decode = LB_ANALOG;
            2'b10: loop_decode = LB_REMOTE;
            2'b11: loop_decode = LB_DIGITAL;
        endcase
    endfunction : loop_decode
endpackage : lcd_pkg

// File: common/lcd_lfsr_if.sv
`timescale 1ns/1ps
interface lcd_lfsr_if;
    logic step;
    logic chk_mode;
    logic long_mode;
    logic rx_bit;
    logic pred;
    modport core (input step, input chk_mode, input long_mode, input rx_bit, output pred);
    modport user (output step, output chk_mode, output long_mode, output rx_bit, input pred);
endinterface : lcd_lfsr_if

// File: verilog/lcd_sync.sv
`timescale 1ns/1ps
module lcd_sync (
    // System
    input  wire logic                    i_clk,
    input  wire logic                    i_nrst,
    // Levels
    input  wire logic [lcd_pkg::LK_W-1:0] i_d,
    output logic      [lcd_pkg::LK_W-1:0] o_q
);
    typedef struct packed {
        logic [lcd_pkg::LK_W-1:0] s1;
        logic [lcd_pkg::LK_W-1:0] s2;
    } lcd_sync_s;

    lcd_sync_s q;
    lcd_sync_s d;

    always_comb begin
        d    = q;
        d.s1 = i_d;
        d.s2 = q.s1;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_q = q.s2;
endmodule : lcd_sync

// File: verilog/lcd_lfsr.sv
`timescale 1ns/1ps
module lcd_lfsr (
    // System
    input wire logic i_clk,
    input wire logic i_nrst,
    // Engine
    lcd_lfsr_if.core lf
);
    typedef struct packed {
        logic [lcd_pkg::LFSR_W-1:0] sr;
    } lcd_lfsr_s;

    lcd_lfsr_s q;
    lcd_lfsr_s d;
    logic      fb;
    logic      dead;

    // Feedback for x^23+x^18+1 or x^15+x^14+1
    assign fb   = lf.long_mode ? (q.sr[lcd_pkg::LONG_TOP] ^ q.sr[lcd_pkg::LONG_TAP])
                               : (q.sr[lcd_pkg::SHRT_TOP] ^ q.sr[lcd_pkg::SHRT_TAP]);
    // A rate change can leave the short window all zero; kick it out
    assign dead = lf.long_mode ? (q.sr == '0) : (q.sr[lcd_pkg::SHRT_TOP:0] == '0);
    assign lf.pred = fb;

    always_comb begin
        d = q;
        if (lf.step) begin
            d.sr = {q.sr[lcd_pkg::LFSR_W-2:0], lf.chk_mode ? lf.rx_bit : (fb | dead)};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            q.sr <= lcd_pkg::LFSR_RST;
        end else begin
            q <= d;
        end
    end
endmodule : lcd_lfsr

// File: verilog/lcd_top.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Summary of operation
// - Pattern enable sends 2^23-1 sequence at E3, 2^15-1 otherwise.
// - Pattern enable also turns on the receive checker, except in digital loop.
// - Checker in sync drives negative/violation output low.
// - Out of sync: sync-lost status reads 1, negative/violation high except in digital loop (send negative data there).
// - Error-insert write corrupts exactly one transmitted pattern bit.
// - Each detected error pulses negative/violation high one receive clock.
// - Only a 0-to-1 change of error-insert arms an injection.
// - Pattern mode forces single-rail whatever dual-rail selects.
// - Three loopback modes chosen by remote and local loop bits.
// - Analog loop feeds line outputs back into receive path.
// - Analog loop keeps driving transmit line outputs.
// - Analog loop ignores the external receive line inputs.
// - Digital loop routes send clock and data to receive outputs.
// - Remote loop retransmits recovered data timed by recovered clock.
// - Remote loop still presents recovered data on receive outputs.
// - Remote loop ignores send clock and send data inputs.
// - All-ones bit sends AMI ones at the send clock rate.
// - All-ones has no effect in analog or remote loop.
// ------------------------------------------------------------
module lcd_top (
    // System
    input  wire logic       i_sys_clk,
    input  wire logic       i_nrst,
    // Register port
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    output logic            o_irq,
    // Terminal side
    input  wire logic       i_send_clock_in,
    input  wire logic       i_send_positive_data,
    input  wire logic       i_send_negative_data,
    output logic            o_recovered_clock_out,
    output logic            o_recovered_positive_data,
    output logic            o_recovered_negative_data,
    // Line side, recovered clock from the CDR
    input  wire logic       i_line_rx_clock,
    input  wire logic       i_line_rx_tip,
    input  wire logic       i_line_rx_ring,
    output logic            o_line_tx_tip,
    output logic            o_line_tx_ring
);
    typedef struct packed {
        logic [7:0]        ctrl;
        logic [2:0]        ev;
        logic [2:0]        mask;
        logic [7:0]        rdata;
        logic              irq;
        logic              ins_pend;
        logic              txc_prev;
        logic              rxc_prev;
        logic              tx_tip;
        logic              tx_ring;
        logic              tx_pol;
        logic              rx_clk;
        logic              rx_pos;
        logic              rx_neg;
        logic              rx_pol;
        lcd_pkg::lcd_chk_e chk;
        logic [5:0]        good;
        logic [2:0]        errs;
    } lcd_top_s;

    lcd_top_s           q;
    lcd_top_s           d;
    logic [5:0]         lk;
    lcd_pkg::lcd_loop_e mode;
    logic               pat;
    logic               aos;
    logic               txc_rise;
    logic               rxc_rise;
    logic               tx_edge;
    logic               rx_edge;
    logic               rx_tip;
    logic               rx_ring;
    logic               rx_bit;
    logic               viol;
    logic               fire;
    logic               arm;
    logic               chk_err;
    logic [2:0]         new_ev;
    logic               tx_bit;

    lcd_lfsr_if gen_if ();
    lcd_lfsr_if chk_if ();

    // ------------------------------------------------------------
    // Pin synchronisers and pattern engines
    // ------------------------------------------------------------
    lcd_sync u_sync (
        .i_clk  (i_sys_clk),
        .i_nrst (i_nrst),
        .i_d    ({i_line_rx_ring, i_line_rx_tip, i_line_rx_clock,
                  i_send_negative_data, i_send_positive_data, i_send_clock_in}),
        .o_q    (lk)
    );

    lcd_lfsr u_gen (
        .i_clk  (i_sys_clk),
        .i_nrst (i_nrst),
        .lf     (gen_if)
    );

    lcd_lfsr u_chk (
        .i_clk  (i_sys_clk),
        .i_nrst (i_nrst),
        .lf     (chk_if)
    );

    // ------------------------------------------------------------
    // Mode decode and timing edges
    // ------------------------------------------------------------
    assign mode     = lcd_pkg::loop_decode(q.ctrl[lcd_pkg::CTL_RLB], q.ctrl[lcd_pkg::CTL_LLB]);
    assign pat      = q.ctrl[lcd_pkg::CTL_PAT];
    assign aos      = q.ctrl[lcd_pkg::CTL_AOS] && mode != lcd_pkg::LB_ANALOG
                      && mode != lcd_pkg::LB_REMOTE;
    assign txc_rise = lk[lcd_pkg::LK_TXC] & ~q.txc_prev;
    assign rxc_rise = lk[lcd_pkg::LK_RXC] & ~q.rxc_prev;
    // Remote loop times the transmitter from the recovered clock
    assign tx_edge  = (mode == lcd_pkg::LB_REMOTE) ? rxc_rise : txc_rise;
    assign rx_edge  = (mode == lcd_pkg::LB_NORMAL || mode == lcd_pkg::LB_REMOTE) ? rxc_rise : txc_rise;
    // Analog loop takes the line outputs and never looks at the line pins
    assign rx_tip   = (mode == lcd_pkg::LB_ANALOG) ? q.tx_tip : lk[lcd_pkg::LK_RXT];
    assign rx_ring  = (mode == lcd_pkg::LB_ANALOG) ? q.tx_ring : lk[lcd_pkg::LK_RXR];
    assign rx_bit   = rx_tip | rx_ring;
    assign viol     = (rx_tip & rx_ring) | (rx_tip & q.rx_pol) | (rx_ring & ~q.rx_pol);

    assign gen_if.step      = tx_edge && pat && mode != lcd_pkg::LB_REMOTE;
    assign gen_if.chk_mode  = 1'b0;
    assign gen_if.long_mode = q.ctrl[lcd_pkg::CTL_E3];
    assign gen_if.rx_bit    = 1'b0;
    // Hunting self-loads from the line; once locked the checker free-runs
    assign chk_if.step      = rx_edge && pat && mode != lcd_pkg::LB_DIGITAL;
    assign chk_if.chk_mode  = (q.chk == lcd_pkg::CHK_HUNT);
    assign chk_if.long_mode = q.ctrl[lcd_pkg::CTL_E3];
    assign chk_if.rx_bit    = rx_bit;

    assign chk_err = chk_if.step && (rx_bit != chk_if.pred);
    assign fire    = gen_if.step && !aos && q.ins_pend;
    assign arm     = i_wr && i_addr == lcd_pkg::CTRL_OFS && i_wdata[lcd_pkg::CTL_INS]
                     && !q.ctrl[lcd_pkg::CTL_INS] && pat;
    assign tx_bit  = aos ? 1'b1 : pat ? (gen_if.pred ^ fire) : lk[lcd_pkg::LK_TXP];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d          = q;
        new_ev     = '0;
        d.txc_prev = lk[lcd_pkg::LK_TXC];
        d.rxc_prev = lk[lcd_pkg::LK_RXC];
        d.rdata    = '0;

        // Register writes
        if (i_wr) begin
            unique case (i_addr)
                lcd_pkg::CTRL_OFS: d.ctrl = i_wdata;
                lcd_pkg::MASK_OFS: d.mask = i_wdata[2:0];
                default: ;
            endcase
        end
        // A new arm wins over the firing of an older one
        d.ins_pend = ((q.ins_pend && !fire) || arm) && pat;

        // Transmit path, kept running in analog loop
        if (tx_edge) begin
            if (mode == lcd_pkg::LB_REMOTE) begin
                d.tx_tip  = lk[lcd_pkg::LK_RXT];
                d.tx_ring = lk[lcd_pkg::LK_RXR];
            end else if (!aos && !pat && q.ctrl[lcd_pkg::CTL_DUAL]) begin
                d.tx_tip  = lk[lcd_pkg::LK_TXP];
                d.tx_ring = lk[lcd_pkg::LK_TXN];
            end else begin
                // Single-rail into AMI: ones alternate tip and ring
                d.tx_tip  = tx_bit & ~q.tx_pol;
                d.tx_ring = tx_bit & q.tx_pol;
                d.tx_pol  = q.tx_pol ^ tx_bit;
            end
        end

        // Checker synchronisation
        if (!pat) begin
            d.chk  = lcd_pkg::CHK_HUNT;
            d.good = '0;
            d.errs = '0;
        end else if (chk_if.step) begin
            unique case (q.chk)
                lcd_pkg::CHK_HUNT: begin
                    d.good = chk_err ? 6'h00 : q.good + 6'h01;
                    if (!chk_err && q.good == lcd_pkg::GOOD_RUN - 6'h01) begin
                        d.chk           = lcd_pkg::CHK_LOCK;
                        d.good          = '0;
                        d.errs          = '0;
                        new_ev[lcd_pkg::EV_GAIN] = 1'b1;
                    end
                end
                lcd_pkg::CHK_LOCK: begin
                    if (chk_err) begin
                        new_ev[lcd_pkg::EV_ERR] = 1'b1;
                        d.errs = q.errs + 3'h1;
                        if (q.errs == lcd_pkg::LOSS_ERR - 3'h1) begin
                            d.chk  = lcd_pkg::CHK_HUNT;
                            d.good = '0;
                            new_ev[lcd_pkg::EV_LOST] = 1'b1;
                        end
                    end else begin
                        d.good = q.good + 6'h01;
                        if (q.good == lcd_pkg::GOOD_RUN - 6'h01) begin
                            d.good = '0;
                            d.errs = '0;
                        end
                    end
                end
            endcase
        end

        // Receive outputs
        d.rx_clk = (mode == lcd_pkg::LB_NORMAL || mode == lcd_pkg::LB_REMOTE) ?
                   lk[lcd_pkg::LK_RXC] : lk[lcd_pkg::LK_TXC];
        if (rx_edge) begin
            if (mode == lcd_pkg::LB_DIGITAL) begin
                d.rx_pos = lk[lcd_pkg::LK_TXP];
                d.rx_neg = lk[lcd_pkg::LK_TXN];
            end else if (pat) begin
                d.rx_pos = rx_bit;
                // Held for exactly one receive clock period
                d.rx_neg = (q.chk == lcd_pkg::CHK_HUNT) || chk_err;
            end else if (q.ctrl[lcd_pkg::CTL_DUAL]) begin
                d.rx_pos = rx_tip;
                d.rx_neg = rx_ring;
            end else begin
                d.rx_pos = rx_bit;
                d.rx_neg = viol;
            end
            if (rx_bit) begin
                d.rx_pol = rx_tip;
            end
        end

        // Reads; the event register clears on read, new events win
        if (i_rd) begin
            unique case (i_addr)
                lcd_pkg::CTRL_OFS: d.rdata = q.ctrl;
                lcd_pkg::STAT_OFS: d.rdata = {mode, 3'h0, pat && q.chk == lcd_pkg::CHK_HUNT};
                lcd_pkg::EVT_OFS:  d.rdata = {5'h00, q.ev};
                lcd_pkg::MASK_OFS: d.rdata = {5'h00, q.mask};
                default:           d.rdata = '0;
            endcase
        end
        d.ev  = ((i_rd && i_addr == lcd_pkg::EVT_OFS) ? 3'h0 : q.ev) | new_ev;
        d.irq = |(d.ev & d.mask);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            q      <= '0;
            q.ctrl <= lcd_pkg::CTRL_RST;
            q.mask <= lcd_pkg::MASK_RST;
            q.ev   <= lcd_pkg::EVT_RST;
            q.chk  <= lcd_pkg::CHK_HUNT;
        end else begin
            q <= d;
        end
    end

    assign o_rdata                   = q.rdata;
    assign o_irq                     = q.irq;
    assign o_line_tx_tip             = q.tx_tip;
    assign o_line_tx_ring            = q.tx_ring;
    assign o_recovered_clock_out     = q.rx_clk;
    assign o_recovered_positive_data = q.rx_pos;
    assign o_recovered_negative_data = q.rx_neg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    a_gen_output: assert property (gen_if.step && !aos && !fire
        |=> (o_line_tx_tip | o_line_tx_ring) == $past(gen_if.pred))
        else $error("line bit differs from generator");

    a_chk_enable: assert property (pat && rx_edge && mode != lcd_pkg::LB_DIGITAL
        |-> chk_if.step)
        else $error("checker not stepped in pattern mode");

    a_lock_low: assert property (pat && rx_edge && q.chk == lcd_pkg::CHK_LOCK && !chk_err
        && mode != lcd_pkg::LB_DIGITAL
        |=> !o_recovered_negative_data)
        else $error("indicator not low while locked");

    // The read must still see hunting; a lock taken on the step itself is no miss
    a_hunt_high: assert property (pat && rx_edge && q.chk == lcd_pkg::CHK_HUNT
        && mode != lcd_pkg::LB_DIGITAL ##1 i_rd && i_addr == lcd_pkg::STAT_OFS
        && pat && q.chk == lcd_pkg::CHK_HUNT |=> o_recovered_negative_data && o_rdata[lcd_pkg::ST_LOST])
        else $error("sync loss not shown");

    a_err_pulse: assert property (chk_err && q.chk == lcd_pkg::CHK_LOCK && mode != lcd_pkg::LB_DIGITAL
        |=> o_recovered_negative_data)
        else $error("detected error not pulsed");

    a_ins_once: assert property (fire && !arm |=> !q.ins_pend)
        else $error("injection not single");

    a_ins_level: assert property (i_wr && i_addr == lcd_pkg::CTRL_OFS
        && q.ctrl[lcd_pkg::CTL_INS] && !q.ins_pend
        |=> !q.ins_pend)
        else $error("rewrite of set insert bit armed");

    a_single_rail: assert property (gen_if.step |=> !(o_line_tx_tip && o_line_tx_ring))
        else $error("pattern mode not single-rail");

    // Only the device's own line outputs may reach the receive side here
    a_analog_feed: assert property (rx_edge && mode == lcd_pkg::LB_ANALOG
        && (pat || !q.ctrl[lcd_pkg::CTL_DUAL])
        |=> o_recovered_positive_data == $past(o_line_tx_tip | o_line_tx_ring))
        else $error("analog loop data not looped");

    a_remote_tx: assert property (tx_edge && mode == lcd_pkg::LB_REMOTE
        |=> o_line_tx_ring == $past(rx_ring))
        else $error("remote loop data not retransmitted");

    a_remote_tip: assert property (tx_edge && mode == lcd_pkg::LB_REMOTE
        |=> o_line_tx_tip == $past(lk[lcd_pkg::LK_RXT]))
        else $error("remote loop took the send pins");

    a_remote_rx: assert property (rx_edge && mode == lcd_pkg::LB_REMOTE && !pat
        && q.ctrl[lcd_pkg::CTL_DUAL]
        |=> o_recovered_negative_data == $past(lk[lcd_pkg::LK_RXR]))
        else $error("remote loop receive data not shown");

    a_digital_clk: assert property (mode == lcd_pkg::LB_DIGITAL
        |=> o_recovered_clock_out == $past(lk[lcd_pkg::LK_TXC]))
        else $error("digital loop clock not routed");

    a_aos_ami: assert property (tx_edge && aos && mode != lcd_pkg::LB_REMOTE
        |=> o_line_tx_tip != o_line_tx_ring)
        else $error("all-ones mark missing");

    a_aos_gated: assert property (tx_edge && mode == lcd_pkg::LB_ANALOG && q.ctrl[lcd_pkg::CTL_AOS]
        && !pat && !q.ctrl[lcd_pkg::CTL_DUAL]
        |=> (o_line_tx_tip | o_line_tx_ring) == $past(lk[lcd_pkg::LK_TXP]))
        else $error("all-ones leaked into analog loop");
endmodule : lcd_top

// File: bench/lcd_line_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Terminal framer and coaxial line
// ----------------------------------------
module lcd_line_model (
    // Line pulses from the device
    input  wire logic i_line_tx_tip,
    input  wire logic i_line_tx_ring,
    // Replace the echo by noise
    input  wire logic i_scramble,
    // Terminal send side
    output logic      o_send_clock,
    output logic      o_send_pos,
    output logic      o_send_neg,
    // Recovered line side
    output logic      o_rx_clock,
    output logic      o_rx_tip,
    output logic      o_rx_ring
);
    logic [31:0] seed_q;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t  = s ^ (s << 13);
        t  = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction : xs

    initial begin
        seed_q       = 32'h31;
        o_send_clock = 1'b0;
        o_send_pos   = 1'b0;
        o_send_neg   = 1'b0;
        o_rx_clock   = 1'b0;
        o_rx_tip     = 1'b0;
        o_rx_ring    = 1'b0;
        forever #80 o_send_clock = ~o_send_clock;
    end

    // Recovered clock lags by 140 ns so the echo is sampled mid-bit
    initial begin
        #140;
        forever #80 o_rx_clock = ~o_rx_clock;
    end

    always @(negedge o_send_clock) begin
        seed_q     = xs(seed_q);
        o_send_pos = seed_q[0];
        o_send_neg = seed_q[1];
    end

    // Noise lets the bench prove the receive pins are ignored
    always @(negedge o_rx_clock) begin
        o_rx_tip  = i_scramble ? seed_q[2] : i_line_tx_tip;
        o_rx_ring = i_scramble ? seed_q[3] : i_line_tx_ring;
    end
endmodule : lcd_line_model

// File: bench/test_line_channel_diagnostics.sv
`timescale 1ns/1ps
module test_line_channel_diagnostics;
    logic        clk;
    logic        nrst;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        irq;
    logic        scr;
    logic        sc, sp, sn, rc, rt, rr, ck, pp, pn, tt, tr;
    logic [31:0] seed;
    logic [7:0]  d;
    logic [7:0]  v;
    int          error_cnt;
    int          samples_checked;
    int          a, b, c;

    lcd_top DUT (.i_sys_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_send_clock_in(sc), .i_send_positive_data(sp),
        .i_send_negative_data(sn), .o_recovered_clock_out(ck), .o_recovered_positive_data(pp),
        .o_recovered_negative_data(pn), .i_line_rx_clock(rc), .i_line_rx_tip(rt),
        .i_line_rx_ring(rr), .o_line_tx_tip(tt), .o_line_tx_ring(tr));

    lcd_line_model u_line (.i_line_tx_tip(tt), .i_line_tx_ring(tr), .i_scramble(scr),
        .o_send_clock(sc), .o_send_pos(sp), .o_send_neg(sn), .o_rx_clock(rc),
        .o_rx_tip(rt), .o_rx_ring(rr));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t  = s ^ (s << 13);
        t  = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction : xs

    function automatic logic [7:0] mode_exp(input int i);
        mode_exp = 8'h10 << i;
    endfunction : mode_exp

    task complete_run;
        $display("counts errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task wr_reg(input logic [3:0] ad, input logic [7:0] dt);
        @(posedge clk);
        addr  <= ad;
        wdata <= dt;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [3:0] ad, output logic [7:0] dt);
        @(posedge clk);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 dt = rdata;
    endtask : rd_reg

    // Per send-clock tallies: loop mismatches, marks, broken alternation
    task per_send(output int dm, output int mk, output int al);
        logic p_sp, p_sn, p_tt;
        dm = 0;
        mk = 0;
        al = 0;
        repeat (3) @(posedge sc);
        p_sp = sp;
        p_sn = sn;
        p_tt = tt;
        repeat (12) begin
            @(posedge sc);
            if ({pp, pn} !== {p_sp, p_sn}) dm++;
            if ((tt | tr) === 1'b1) mk++;
            if (tt === p_tt || (tt & tr) !== 1'b0) al++;
            p_sp = sp;
            p_sn = sn;
            p_tt = tt;
        end
    endtask : per_send

    task inject(input logic [7:0] cv, output int np);
        int  mk;
        logic last;
        np = 0;
        mk = 0;
        wr_reg(lcd_pkg::CTRL_OFS, cv);
        #1 last = pn;
        repeat (400) begin
            @(posedge clk);
            #1;
            if (pn === 1'b1 && last === 1'b0) np++;
            if (tt === 1'b1) mk++;
            last = pn;
        end
        chk("line_marks", 8'(mk != 0), 8'h01);
    endtask : inject

    initial begin
        nrst = 1'b0; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0; scr = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        seed = 32'h31;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(lcd_pkg::CTRL_OFS, d); chk("ctrl_reset", d, 8'h00);
        rd_reg(lcd_pkg::MASK_OFS, d); chk("mask_reset", d, 8'h00);
        rd_reg(4'h9, d); chk("unmapped", d, 8'h00);
        @(posedge clk); #1 chk("rdata_idle", rdata, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            v = (seed[7:0] & 8'hf0) | {4'h0, i[0], i[1], 2'b00};
            wr_reg(lcd_pkg::CTRL_OFS, v);
            rd_reg(lcd_pkg::CTRL_OFS, d); chk("ctrl", d, v);
            rd_reg(lcd_pkg::STAT_OFS, d); chk("stat", d, mode_exp(i));
        end
        $display("test registers done");
        wr_reg(lcd_pkg::CTRL_OFS, 8'h0c);
        per_send(a, b, c); chk("digital_loop", 8'(a), 8'h00);
        @(negedge sc); #1 chk("digital_clk_hi", 8'(ck), 8'h01);
        @(posedge sc); #1 chk("digital_clk_lo", 8'(ck), 8'h00);
        scr = 1'b1;
        wr_reg(lcd_pkg::CTRL_OFS, 8'h24);
        @(posedge rc);
        repeat (2) @(posedge rc);
        a = 0;
        b = 0;
        v[2:0] = {rt, rr, rt | rr};
        repeat (12) begin
            @(posedge rc);
            if ((tt | tr) !== v[0]) a++;
            if ({pp, pn} !== v[2:1]) b++;
            v[2:0] = {rt, rr, rt | rr};
        end
        chk("remote_tx", 8'(a), 8'h00);
        chk("remote_rx", 8'(b), 8'h00);
        @(negedge rc); #1 chk("remote_clk", 8'(ck), 8'h01);
        $display("test loops done");
        wr_reg(lcd_pkg::CTRL_OFS, 8'h10);
        per_send(a, b, c); chk("ones_marks", 8'(b), 8'h0c); chk("ones_alt", 8'(c), 8'h00);
        wr_reg(lcd_pkg::CTRL_OFS, 8'h1c);
        per_send(a, b, c); chk("ones_digital", 8'(b), 8'h0c);
        wr_reg(lcd_pkg::CTRL_OFS, 8'h18);
        per_send(a, b, c); chk("ones_analog", 8'(b < 12), 8'h01);
        $display("test all ones done");
        wr_reg(lcd_pkg::MASK_OFS, 8'h04);
        for (int k = 0; k < 2; k++) begin
            v = k ? 8'h69 : 8'h29;
            wr_reg(lcd_pkg::CTRL_OFS, 8'h00);
            wr_reg(lcd_pkg::CTRL_OFS, v);
            repeat (2) @(posedge sc);
            chk("hunt_ind", 8'(pn), 8'h01);
            rd_reg(lcd_pkg::STAT_OFS, d); chk("sync_lost", 8'(d[0]), 8'h01);
            for (a = 0; a < 3000 && pn !== 1'b0; a++) begin
                @(posedge clk);
                #1;
            end
            if (a == 3000) begin
                error_cnt++;
                $display("unexpected lock wait expected 0 seen 1");
                complete_run;
            end
            #1 chk("lock_ind", 8'(pn), 8'h00);
            rd_reg(lcd_pkg::STAT_OFS, d); chk("sync_ok", 8'(d[0]), 8'h00);
            rd_reg(lcd_pkg::EVT_OFS, d); chk("ev_gain", 8'(d[1]), 8'h01);
            chk("irq_masked", 8'(irq), 8'h00);
            inject(v | 8'h02, a); chk("pulses", 8'(a), 8'h01);
            chk("irq_err", 8'(irq), 8'h01);
            rd_reg(lcd_pkg::EVT_OFS, d); chk("ev_err", 8'(d[2]), 8'h01);
            @(posedge clk); #1 chk("irq_clear", 8'(irq), 8'h00);
            inject(v | 8'h02, a); chk("no_rearm", 8'(a), 8'h00);
            wr_reg(lcd_pkg::CTRL_OFS, v);
            inject(v | 8'h02, a); chk("rearm", 8'(a), 8'h01);
            $display("test pattern rate %0d done", k);
        end
        complete_run;
    end
endmodule : test_line_channel_diagnostics
